// *** verilog/acts_pkg.sv ***
package acts_pkg;
  localparam int ACTS_NCH = 22;
  localparam int ACTS_SELW = 5;
  localparam int ACTS_TRIG_WORDS = 12;
  localparam int ACTS_AW = 12;
  // Byte offsets of the register words
  localparam logic [11:0] ACTS_OFF_MODE_MID = 12'h000;
  localparam logic [11:0] ACTS_OFF_MODE_HIGH = 12'h004;
  localparam logic [11:0] ACTS_OFF_IRQ_EN_LOW = 12'h008;
  localparam logic [11:0] ACTS_OFF_IRQ_EN_HIGH = 12'h00C;
  localparam logic [11:0] ACTS_OFF_RDY_LOW = 12'h010;
  localparam logic [11:0] ACTS_OFF_RDY_HIGH = 12'h014;
  localparam logic [11:0] ACTS_OFF_LVL_LOW = 12'h018;
  localparam logic [11:0] ACTS_OFF_LVL_HIGH = 12'h01C;
  localparam logic [11:0] ACTS_OFF_IRQ_STAT = 12'h020;
  localparam logic [11:0] ACTS_OFF_IRQ_MASK = 12'h024;
  localparam logic [11:0] ACTS_OFF_TRIG_BASE = 12'h040;
  localparam logic [11:0] ACTS_OFF_TRIG_END = 12'h070;
  // Field positions inside a selector word
  localparam int ACTS_SEL_LO_POS = 0;
  localparam int ACTS_SEL_HI_POS = 8;
  localparam int ACTS_MODE_HIGH_W = 12;
  localparam logic [15:0] ACTS_RST16 = 16'h0000;
  localparam logic [21:0] ACTS_RST22 = 22'h000000;
  // Trigger source codes
  localparam logic [4:0] ACTS_SRC_NONE = 5'h00;
  localparam logic [4:0] ACTS_SRC_COMMON_SW = 5'h01;
  localparam logic [4:0] ACTS_SRC_LEVEL_SW = 5'h02;
  localparam logic [4:0] ACTS_SRC_PWM_SPECIAL = 5'h04;
  localparam logic [4:0] ACTS_SRC_PWM_PRI1 = 5'h05;
  localparam logic [4:0] ACTS_SRC_PWM_PRI5 = 5'h09;
  localparam logic [4:0] ACTS_SRC_TMR1 = 5'h0C;
  localparam logic [4:0] ACTS_SRC_TMR2 = 5'h0D;
  localparam logic [4:0] ACTS_SRC_PWM_SEC_SPECIAL = 5'h0E;
  localparam logic [4:0] ACTS_SRC_PWM_SEC1 = 5'h0F;
  localparam logic [4:0] ACTS_SRC_PWM_SEC5 = 5'h13;
  localparam logic [4:0] ACTS_SRC_OC1 = 5'h16;
  localparam logic [4:0] ACTS_SRC_OC2 = 5'h17;
  localparam logic [4:0] ACTS_SRC_CLIM1 = 5'h18;
  localparam logic [4:0] ACTS_SRC_CLIM5 = 5'h1C;
  localparam logic [4:0] ACTS_SRC_EXT = 5'h1F;

  typedef struct packed {
    logic common_sw;
    logic level_sw;
    logic pwm_special;
    logic [4:0] pwm_pri;
    logic tmr1;
    logic tmr2;
    logic pwm_sec_special;
    logic [4:0] pwm_sec;
    logic oc1;
    logic oc2;
    logic [4:0] pwm_climit;
  } acts_trig_src_t;

  typedef struct packed {
    logic [21:16] differential_select;
    logic [21:8] sign_select;
  } acts_mode_t;
endpackage : acts_pkg

// *** verilog/acts_sync2.sv ***
`timescale 1ns/10ps
module acts_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level crossing
  input wire logic din,
  output logic dout
);
  import acts_pkg::*;
  logic meta_r;
  logic sync_r;

  // Second stage is the only reader of the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule : acts_sync2

// *** verilog/acts_trig_mux.sv ***
`timescale 1ns/10ps
module acts_trig_mux (
  // Selection
  input wire logic [4:0] sel,
  input wire acts_pkg::acts_trig_src_t src,
  input wire logic ext_trig,
  // Selected source level
  output logic hit
);
  import acts_pkg::*;

  function automatic logic in_range(input logic [4:0] v, input logic [4:0] lo,
                                    input logic [4:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  always_comb begin
    hit = 1'b0;
    // R8 none and software
    if (sel == ACTS_SRC_COMMON_SW) hit = src.common_sw;
    if (sel == ACTS_SRC_LEVEL_SW) hit = src.level_sw;
    // R9 PWM primary triggers
    if (sel == ACTS_SRC_PWM_SPECIAL) hit = src.pwm_special;
    if (in_range(sel, ACTS_SRC_PWM_PRI1, ACTS_SRC_PWM_PRI5))
      hit = src.pwm_pri[3'(sel - ACTS_SRC_PWM_PRI1)];
    // R10 timer period matches
    if (sel == ACTS_SRC_TMR1) hit = src.tmr1;
    if (sel == ACTS_SRC_TMR2) hit = src.tmr2;
    // R11 PWM secondary triggers
    if (sel == ACTS_SRC_PWM_SEC_SPECIAL) hit = src.pwm_sec_special;
    if (in_range(sel, ACTS_SRC_PWM_SEC1, ACTS_SRC_PWM_SEC5))
      hit = src.pwm_sec[3'(sel - ACTS_SRC_PWM_SEC1)];
    // R12 output compare
    if (sel == ACTS_SRC_OC1) hit = src.oc1;
    if (sel == ACTS_SRC_OC2) hit = src.oc2;
    // R13 current-limit triggers
    if (in_range(sel, ACTS_SRC_CLIM1, ACTS_SRC_CLIM5))
      hit = src.pwm_climit[3'(sel - ACTS_SRC_CLIM1)];
    // R14 reserved codes stay silent
    if (sel == ACTS_SRC_EXT) hit = ext_trig;
  end
endmodule : acts_trig_mux

// *** verilog/acts_ctrl.sv ***
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
// How it works
// R1: Odd mode bit selects differential, channels 16-21
// R2: SIGN bit one selects signed, channels 8-21
// R3: Unimplemented bits ignore writes, read zero; the odd mode_mid_r bits are stored and read back
// R4: Per-channel enable gates common and channel interrupts
// R5: Ready flag set when result available
// R6: Ready flags read-only, hardware sets and clears
// R7: Five-bit selector per channel, two per word
// R8: Code 0 none, 1 common, 2 level software
// R9: Code 4 special event, 5-9 PWM primary
// R10: Codes 12, 13 timer 1, 2 period match
// R11: Code 14 secondary special, 15-19 PWM secondary
// R12: Codes 22, 23 output compare 1, 2
// R13: Codes 24-28 PWM current-limit triggers
// R14: Software avoids reserved codes; 31 external
// R15: All control and ready bits reset zero
// R16: Level-enable bit picks level or edge trigger
// R17: Buffer read clears ready; new result sets
module acts_ctrl #(
  parameter int NCH = acts_pkg::ACTS_NCH
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire acts_pkg::acts_trig_src_t trig_src,
  input wire logic external_trigger_input,
  // Conversion core side
  input wire logic conv_done,
  input wire logic [4:0] conv_chan,
  input wire logic buf_read,
  input wire logic [4:0] buf_read_chan,
  output logic [21:0] trig_req,
  output acts_pkg::acts_mode_t chan_mode,
  // Interrupts
  output logic [21:0] chan_irq,
  output logic irq
);
  import acts_pkg::*;

  initial begin
    if (NCH != ACTS_NCH) $error("acts_ctrl serves exactly 22 channels");
  end

  logic [15:0] mode_mid_r;
  logic [ACTS_MODE_HIGH_W-1:0] mode_high_r;
  logic [21:0] irq_en_r;
  logic [21:0] lvl_en_r;
  logic [21:0] ready_r;
  logic [21:0] sticky_r;
  logic [21:0] mask_r;
  logic [4:0] sel_r [0:21];
  logic [21:0] hit;
  logic [21:0] hit_prev_r;
  logic [21:0] trig_req_r;
  logic [21:0] chan_irq_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic ext_sync;
  logic wr_en;
  logic setup;
  logic [21:0] done_vec;
  logic [21:0] read_vec;

  function automatic logic [21:0] onehot(input logic fire, input logic [4:0] ch);
    onehot = '0;
    if (fire && ch < 5'd22) onehot[ch] = 1'b1;
  endfunction : onehot

  function automatic logic is_trig(input logic [11:0] a);
    is_trig = (a >= ACTS_OFF_TRIG_BASE) && (a < ACTS_OFF_TRIG_END);
  endfunction : is_trig

  function automatic logic [3:0] trig_word(input logic [11:0] a);
    logic [11:0] d;
    d = a - ACTS_OFF_TRIG_BASE;
    trig_word = d[5:2];
  endfunction : trig_word

  function automatic logic mapped(input logic [11:0] a);
    mapped = is_trig(a) || (a[1:0] == 2'b00 && a <= ACTS_OFF_IRQ_MASK);
  endfunction : mapped

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_r && mapped(paddr);
  assign done_vec = onehot(conv_done, conv_chan);
  assign read_vec = onehot(buf_read, buf_read_chan);

  acts_sync2 u_ext_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(external_trigger_input),
    .dout(ext_sync)
  );

  // Answer one cycle after setup; pready drops after the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped(paddr);
    end
  end

  // R3 unused bits read zero, except the odd mode_mid_r bits, which read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup && !pwrite) begin
      prdata_r <= '0;
      if (is_trig(paddr)) begin
        prdata_r[ACTS_SEL_LO_POS +: 5] <= (2 * trig_word(paddr) < 22) ?
                                          sel_r[5'(2 * trig_word(paddr))] : 5'h00;
        prdata_r[ACTS_SEL_HI_POS +: 5] <= (2 * trig_word(paddr) + 1 < 22) ?
                                          sel_r[5'(2 * trig_word(paddr) + 1)] : 5'h00;
      end else begin
        unique case (paddr)
          ACTS_OFF_MODE_MID: prdata_r[15:0] <= mode_mid_r;
          ACTS_OFF_MODE_HIGH: prdata_r[11:0] <= mode_high_r;
          ACTS_OFF_IRQ_EN_LOW: prdata_r[15:0] <= irq_en_r[15:0];
          ACTS_OFF_IRQ_EN_HIGH: prdata_r[5:0] <= irq_en_r[21:16];
          ACTS_OFF_RDY_LOW: prdata_r[15:0] <= ready_r[15:0];
          ACTS_OFF_RDY_HIGH: prdata_r[5:0] <= ready_r[21:16];
          ACTS_OFF_LVL_LOW: prdata_r[15:0] <= lvl_en_r[15:0];
          ACTS_OFF_LVL_HIGH: prdata_r[5:0] <= lvl_en_r[21:16];
          ACTS_OFF_IRQ_STAT: prdata_r[21:0] <= sticky_r;
          ACTS_OFF_IRQ_MASK: prdata_r[21:0] <= mask_r;
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  // R1 R2 R15 mode bits, zero at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_mid_r <= ACTS_RST16;
      mode_high_r <= '0;
    end else if (wr_en && paddr == ACTS_OFF_MODE_MID) begin
      mode_mid_r <= pwdata[15:0];
    end else if (wr_en && paddr == ACTS_OFF_MODE_HIGH) begin
      mode_high_r <= pwdata[ACTS_MODE_HIGH_W-1:0];
    end
  end

  // R4 R16 enable words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= ACTS_RST22;
      lvl_en_r <= ACTS_RST22;
      mask_r <= ACTS_RST22;
    end else if (wr_en) begin
      unique case (paddr)
        ACTS_OFF_IRQ_EN_LOW: irq_en_r[15:0] <= pwdata[15:0];
        ACTS_OFF_IRQ_EN_HIGH: irq_en_r[21:16] <= pwdata[5:0];
        ACTS_OFF_LVL_LOW: lvl_en_r[15:0] <= pwdata[15:0];
        ACTS_OFF_LVL_HIGH: lvl_en_r[21:16] <= pwdata[5:0];
        ACTS_OFF_IRQ_MASK: mask_r <= pwdata[21:0];
        default: ;
      endcase
    end
  end

  // R5 R6 R17 ready flags, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= ACTS_RST22;
    end else begin
      ready_r <= (ready_r & ~read_vec) | done_vec;
    end
  end

  // Set beats a same-cycle clear so no event is lost
  // R4 sticky status only for enabled channels; write one clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_r <= ACTS_RST22;
    end else if (wr_en && paddr == ACTS_OFF_IRQ_STAT) begin
      sticky_r <= (sticky_r & ~pwdata[21:0]) | (done_vec & irq_en_r);
    end else begin
      sticky_r <= sticky_r | (done_vec & irq_en_r);
    end
  end

  // R4 interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_irq_r <= ACTS_RST22;
      irq_r <= 1'b0;
    end else begin
      chan_irq_r <= ready_r & irq_en_r;
      irq_r <= |(sticky_r & mask_r & irq_en_r);
    end
  end

  genvar c;
  generate
    for (c = 0; c < 22; c++) begin : g_chan
      // R7 selector for channel c
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_r[c] <= ACTS_SRC_NONE;
        end else if (wr_en && is_trig(paddr) && trig_word(paddr) == 4'(c / 2)) begin
          sel_r[c] <= pwdata[(c % 2) * ACTS_SEL_HI_POS +: 5];
        end
      end

      acts_trig_mux u_mux (
        .sel(sel_r[c]),
        .src(trig_src),
        .ext_trig(ext_sync),
        .hit(hit[c])
      );

      // R16 level or rising edge
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hit_prev_r[c] <= 1'b0;
          trig_req_r[c] <= 1'b0;
        end else begin
          hit_prev_r[c] <= hit[c];
          trig_req_r[c] <= lvl_en_r[c] ? hit[c] : (hit[c] && !hit_prev_r[c]);
        end
      end
    end
  endgenerate

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign trig_req = trig_req_r;
  assign chan_irq = chan_irq_r;
  assign irq = irq_r;
  assign chan_mode.differential_select = {mode_high_r[11], mode_high_r[9], mode_high_r[7],
                                          mode_high_r[5], mode_high_r[3], mode_high_r[1]};
  assign chan_mode.sign_select = {mode_high_r[10], mode_high_r[8], mode_high_r[6],
                                  mode_high_r[4], mode_high_r[2], mode_high_r[0],
                                  mode_mid_r[14], mode_mid_r[12], mode_mid_r[10],
                                  mode_mid_r[8], mode_mid_r[6], mode_mid_r[4],
                                  mode_mid_r[2], mode_mid_r[0]};

  sequence s_wr_high;
    wr_en && paddr == ACTS_OFF_MODE_HIGH;
  endsequence

  property p_differential_select_write;
    @(posedge pclk) disable iff (!presetn)
    s_wr_high |=> chan_mode.differential_select[16] == $past(pwdata[1]);
  endproperty
  a_differential_select_write: assert property (p_differential_select_write) else $error("differential_select bit mismatch"); // R1

  property p_sign_write;
    @(posedge pclk) disable iff (!presetn)
    s_wr_high |=> chan_mode.sign_select[21] == $past(pwdata[10]);
  endproperty
  a_sign_write: assert property (p_sign_write) else $error("sign bit mismatch"); // R2

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ACTS_OFF_MODE_HIGH) |=> prdata[31:12] == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused bits nonzero"); // R3

  property p_ie_gate;
    @(posedge pclk) disable iff (!presetn)
    ((done_vec & ~irq_en_r) != 22'h0)
      |=> (sticky_r & ~$past(sticky_r) & $past(done_vec) & ~$past(irq_en_r)) == 22'h0;
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("disabled channel flagged"); // R4

  property p_ready_set;
    @(posedge pclk) disable iff (!presetn)
    (done_vec != 22'h0) |=> (ready_r & $past(done_vec)) == $past(done_vec);
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set"); // R5

  property p_ready_ro;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ACTS_OFF_RDY_LOW && !conv_done && !buf_read) |=> $stable(ready_r);
  endproperty
  a_ready_ro: assert property (p_ready_ro) else $error("ready written by bus"); // R6

  property p_none_quiet;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ACTS_SRC_NONE)[*2] |-> !trig_req_r[0];
  endproperty
  a_none_quiet: assert property (p_none_quiet) else $error("trigger with no source"); // R8

  property p_tmr1_level;
    @(posedge pclk) disable iff (!presetn)
    (lvl_en_r[1] && sel_r[1] == ACTS_SRC_TMR1 && trig_src.tmr1) |=> trig_req_r[1];
  endproperty
  a_tmr1_level: assert property (p_tmr1_level) else $error("timer trigger lost"); // R10

  sequence s_held_edge;
    (!lvl_en_r[2] && hit[2])[*2];
  endsequence

  property p_edge_once;
    @(posedge pclk) disable iff (!presetn)
    s_held_edge |=> !trig_req_r[2];
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge mode retriggered"); // R16

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
    ((read_vec & ~done_vec) != 22'h0)
      |=> (ready_r & $past(read_vec) & ~$past(done_vec)) == 22'h0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read left ready set"); // R17

  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ACTS_OFF_TRIG_BASE)
      |=> sel_r[0] == $past(pwdata[4:0]) && sel_r[1] == $past(pwdata[12:8]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector write lost"); // R7

  property p_unimpl_trig;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && is_trig(paddr)) |=> prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0;
  endproperty
  a_unimpl_trig: assert property (p_unimpl_trig) else $error("selector gap nonzero"); // R3

  property p_sticky_w1c;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ACTS_OFF_IRQ_STAT && !conv_done)
      |=> (sticky_r & $past(pwdata[21:0])) == 22'h0;
  endproperty
  a_sticky_w1c: assert property (p_sticky_w1c) else $error("status not cleared"); // R4

  property p_reset_quiet;
    @(posedge pclk)
    !presetn |-> ready_r == 22'h0 && sticky_r == 22'h0 && trig_req_r == 22'h0
      && sel_r[0] == ACTS_SRC_NONE;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("state not cleared"); // R15
endmodule : acts_ctrl

// *** sim/acts_trig_model.sv ***
`timescale 1ns/10ps
module acts_trig_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic go,
  input wire logic [4:0] code,
  input wire logic [3:0] len,
  // Trigger levels
  output acts_pkg::acts_trig_src_t src,
  output logic ext
);
  import acts_pkg::*;
  logic [3:0] left_r;
  logic [4:0] code_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 4'h0;
      code_r <= 5'h00;
    end else if (go) begin
      left_r <= len;
      code_r <= code;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  // Codes with no source raise every source, so a stray decode shows
  always_comb begin
    src = '0;
    ext = 1'b0;
    if (left_r != 4'h0) begin
      case (code_r) inside
        5'h01: src.common_sw = 1'b1;
        5'h02: src.level_sw = 1'b1;
        5'h04: src.pwm_special = 1'b1;
        [5'h05:5'h09]: src.pwm_pri = 5'h01 << (code_r - 5'h05);
        5'h0C: src.tmr1 = 1'b1;
        5'h0D: src.tmr2 = 1'b1;
        5'h0E: src.pwm_sec_special = 1'b1;
        [5'h0F:5'h13]: src.pwm_sec = 5'h01 << (code_r - 5'h0F);
        5'h16: src.oc1 = 1'b1;
        5'h17: src.oc2 = 1'b1;
        [5'h18:5'h1C]: src.pwm_climit = 5'h01 << (code_r - 5'h18);
        5'h1F: ext = 1'b1;
        default: begin
          src = '1;
          ext = 1'b1;
        end
      endcase
    end
  end
endmodule : acts_trig_model

// *** sim/adc_channel_cfg_trigger_select_test.sv ***
`timescale 1ns/10ps
module adc_channel_cfg_trigger_select_test;
  import acts_pkg::*;
  typedef struct packed {
    logic rd;
    logic [31:0] d;
    logic e;
  } acts_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  acts_trig_src_t trig_src;
  logic ext_in;
  logic conv_done = 1'b0;
  logic buf_read = 1'b0;
  logic [4:0] chan = 5'h00;
  logic [21:0] trig_req;
  acts_mode_t chan_mode;
  logic [21:0] chan_irq;
  logic irq;
  logic go = 1'b0;
  logic [4:0] code = 5'h00;
  logic [3:0] len = 4'h0;
  int err_count = 0;
  int check_count = 0;
  acts_exp_t exp_q[$];
  acts_exp_t ex;
  localparam logic [31:0] MSK [10] = '{32'hFFFF, 32'h0FFF, 32'hFFFF, 32'h003F, 32'h0,
    32'h0, 32'hFFFF, 32'h003F, 32'h0, 32'h3FFFFF};

  always #50 pclk = ~pclk;

  acts_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_src(trig_src), .external_trigger_input(ext_in),
    .conv_done(conv_done), .conv_chan(chan), .buf_read(buf_read), .buf_read_chan(chan),
    .trig_req(trig_req), .chan_mode(chan_mode), .chan_irq(chan_irq), .irq(irq));
  acts_trig_model i_model (.clk(pclk), .rst_n(presetn), .go(go), .code(code), .len(len),
    .src(trig_src), .ext(ext_in));

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t read exp %h got %h", $time, e, g);
    end
  endtask : cmp_rd

  task automatic cmp_out(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t out exp %h got %h", $time, e, g);
    end
  endtask : cmp_out

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({!w, w ? 32'h0 : e, er});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Answers are judged where the bus completes them
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      ex = exp_q.pop_front();
      cmp_rd({ex.d, ex.e}, {ex.rd ? prdata : 32'h0, pslverr});
    end
  end

  task automatic pulse(input logic dn, input logic [4:0] c);
    @(posedge pclk);
    chan <= c;
    conv_done <= dn;
    buf_read <= !dn;
    @(posedge pclk);
    conv_done <= 1'b0;
    buf_read <= 1'b0;
  endtask : pulse

  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic fire(input logic [4:0] c, input logic [3:0] l, input int ch, input int eh,
      input int ef);
    int hits;
    int first;
    hits = 0;
    first = 0;
    @(posedge pclk);
    code <= c;
    len <= l;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int i = 1; i < 9; i++) begin
      @(negedge pclk);
      if (trig_req[ch] === 1'b1) begin
        hits++;
        if (first == 0) first = i;
      end
      @(posedge pclk);
    end
    cmp_out({eh[15:0], ef[15:0]}, {hits[15:0], first[15:0]});
  endtask : fire

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #(100 * 20000);
    err_count++;
    end_of_test();
  end

  initial begin
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] x;
    int c;
    int v;
    void'($urandom(32'hE54698E4));
    // Falling edge at time zero, from the initial one, so the async reset is seen
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      a = (i < 10) ? 12'(4 * i) : 12'h040 + 12'(4 * (i - 10));
      m = (i < 10) ? MSK[i] : ((i < 21) ? 32'h1F1F : 32'h0);
      d = $urandom;
      apb(1'b0, a, 32'h0, 32'h0, 1'b0);
      apb(1'b1, a, d, 32'h0, 1'b0);
      apb(1'b0, a, 32'h0, d & m, 1'b0);
      apb(1'b1, a, 32'h0, 32'h0, 1'b0);
    end
    apb(1'b0, 12'h800, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h800, 32'h1, 32'h0, 1'b1);
    d = $urandom;
    m = $urandom;
    apb(1'b1, 12'h000, d, 32'h0, 1'b0);
    apb(1'b1, 12'h004, m, 32'h0, 1'b0);
    x = 32'h0;
    for (int k = 0; k < 14; k++) begin
      x[k] = (k < 8) ? d[2 * k] : m[2 * (k - 8)];
      if (k > 7) x[k + 6] = m[2 * (k - 8) + 1];
    end
    settle();
    cmp_out(x, {12'h0, chan_mode});
    c = $urandom % 16;
    apb(1'b1, 12'h008, 32'h1 << c, 32'h0, 1'b0);
    apb(1'b1, 12'h024, 32'h1 << c, 32'h0, 1'b0);
    pulse(1'b1, 5'(c));
    settle();
    cmp_out({chan_irq, irq}, {22'h1 << c, 1'b1});
    apb(1'b0, 12'h010, 32'h0, 32'h1 << c, 1'b0);
    apb(1'b1, 12'h024, 32'h0, 32'h0, 1'b0);
    settle();
    cmp_out({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h024, 32'h1 << c, 32'h0, 1'b0);
    settle();
    cmp_out({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h020, 32'h1 << c, 32'h0, 1'b0);
    settle();
    cmp_out({31'h0, irq}, 32'h0);
    pulse(1'b0, 5'(c));
    settle();
    cmp_out({10'h0, chan_irq}, 32'h0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
    pulse(1'b1, 5'd21);
    settle();
    cmp_out({chan_irq, irq}, 32'h0);
    apb(1'b0, 12'h014, 32'h0, 32'h20, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b0);
    for (int k = 0; k < 32; k++) begin
      c = $urandom % 22;
      a = 12'h040 + 12'(4 * (c / 2));
      apb(1'b1, a, 32'(k) << (8 * (c % 2)), 32'h0, 1'b0);
      v = !(k inside {0, 3, 10, 11, 20, 21, 29, 30});
      fire(5'(k), 4'h2, c, v, v ? ((k == 31) ? 4 : 2) : 0);
      apb(1'b1, a, 32'h0, 32'h0, 1'b0);
    end
    c = $urandom % 22;
    apb(1'b1, (c < 16) ? 12'h018 : 12'h01C, 32'h1 << (c % 16), 32'h0, 1'b0);
    apb(1'b1, 12'h040 + 12'(4 * (c / 2)), 32'h0C << (8 * (c % 2)), 32'h0, 1'b0);
    fire(5'h0C, 4'h3, c, 3, 2);
    end_of_test();
  end
endmodule : adc_channel_cfg_trigger_select_test
